/* dv/crdo_assertions.sv */
// ---------------------------------------------------------------
// Checker for the command side
// ---------------------------------------------------------------
module crdo_checker #(
  parameter int MAX_RL = crdo_pkg::RL_MAX_DEFAULT
) (
  input wire logic                   sys_clk,
  input wire logic                   reset_n,
  input wire logic                   fill_zero,
  input wire logic                   mpr_active,
  input wire logic                   dll_off,
  input wire logic [15:0]            mpr_read_count,
  input wire logic                   dram_ck,
  input wire crdo_pkg::crdo_cmd_type cmd,
  input wire logic [2:0]             ba,
  input wire logic [15:0]            addr,
  input wire logic [127:0]           arr_rdata,
  input wire crdo_pkg::crdo_arr_type arr_req,
  input wire logic [15:0]            dq_rise,
  input wire logic [15:0]            dq_fall,
  input wire logic                   dq_oe_n
);
  logic [15:0] mr0_r;
  logic [15:0] mr1_r;
  logic [15:0] mr3_r;
  wire rd    = (cmd == 4'h5);
  wire wr    = (cmd == 4'h4);
  wire calibration_pattern_register   = mr3_r[2];
  wire base6 = (mr0_r[6:4] == 3'h2) && (mr1_r[4:3] == 2'h0);

  // Shadow mode registers, loaded by mode register set commands.
  always_ff @(posedge dram_ck or negedge reset_n) begin
    if (!reset_n) begin
      mr0_r <= 16'h0000;
      mr1_r <= 16'h0000;
      mr3_r <= 16'h0000;
    end else if (cmd == 4'h0 && !ba[2]) begin
      if (ba[1:0] == 2'h0) mr0_r <= addr;
      if (ba[1:0] == 2'h1) mr1_r <= addr;
      if (ba[1:0] == 2'h3) mr3_r <= addr;
    end
  end

  // Data launched at edge RL is first sampled low one edge later.
  sequence s_quiet6; dq_oe_n [*6]; endsequence
  sequence s_quiet5; dq_oe_n [*5]; endsequence
  sequence s_bl8_tail; !dq_oe_n [*4] ##1 dq_oe_n; endsequence
  sequence s_bc4_tail; !dq_oe_n [*2] ##1 dq_oe_n; endsequence

  property p_rl_on;
    @(posedge dram_ck) disable iff (!reset_n)
    rd && base6 && !mr1_r[0] |-> ##1 s_quiet6 ##1 !dq_oe_n;
  endproperty
  a_rl_on: assert property (p_rl_on) else $error("late read data");
  property p_rl_off;
    @(posedge dram_ck) disable iff (!reset_n)
    rd && base6 && mr1_r[0] |-> ##1 s_quiet5 ##1 !dq_oe_n;
  endproperty
  a_rl_off: assert property (p_rl_off) else $error("dll off latency");
  property p_bl8;
    @(posedge dram_ck) disable iff (!reset_n)
    $fell(dq_oe_n) && mr0_r[1:0] == 2'h0 |-> s_bl8_tail;
  endproperty
  a_bl8: assert property (p_bl8) else $error("burst of eight");
  property p_bc4;
    @(posedge dram_ck) disable iff (!reset_n)
    $fell(dq_oe_n) && mr0_r[1:0] == 2'h2 |-> s_bc4_tail;
  endproperty
  a_bc4: assert property (p_bc4) else $error("fixed chop");
  property p_mpr_no_arr;
    @(posedge dram_ck) disable iff (!reset_n)
    rd && calibration_pattern_register |=> !arr_req.valid;
  endproperty
  a_mpr_no_arr: assert property (p_mpr_no_arr)
    else $error("array hit");
  property p_arr_rd;
    @(posedge dram_ck) disable iff (!reset_n)
    rd && !calibration_pattern_register |=> arr_req.valid && !arr_req.write &&
      arr_req.bank == $past(ba) && arr_req.col == $past(addr[9:0]) &&
      arr_req.auto_pre == $past(addr[10]);
  endproperty
  a_arr_rd: assert property (p_arr_rd) else $error("no array read");
  property p_arr_wr;
    @(posedge dram_ck) disable iff (!reset_n)
    wr && !calibration_pattern_register |=> arr_req.valid && arr_req.write;
  endproperty
  a_arr_wr: assert property (p_arr_wr) else $error("no array write");
  property p_idle;
    @(posedge dram_ck) disable iff (!reset_n)
    cmd.cs_n || cmd == 4'h7 |=> !arr_req.valid;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle cmd acted");
  property p_pattern;
    @(posedge dram_ck) disable iff (!reset_n)
    !dq_oe_n && calibration_pattern_register && mr3_r[1:0] == 2'h0 |-> dq_rise == 16'h0000 &&
      dq_fall == {2{fill_zero ? 8'h01 : 8'hFF}};
  endproperty
  a_pattern: assert property (p_pattern)
    else $error("bad pattern");
  property p_count;
    @(posedge sys_clk) disable iff (!reset_n)
    $changed(mpr_read_count) |-> mpr_read_count == $past(mpr_read_count) + 16'h1;
  endproperty
  a_count: assert property (p_count) else $error("count step");
endmodule : crdo_checker

bind crdo_top crdo_checker #(.MAX_RL(MAX_RL)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .fill_zero(fill_zero),
  .mpr_active(mpr_active), .dll_off(dll_off),
  .mpr_read_count(mpr_read_count), .dram_ck(dram_ck), .cmd(cmd),
  .ba(ba), .addr(addr), .arr_rdata(arr_rdata), .arr_req(arr_req),
  .dq_rise(dq_rise), .dq_fall(dq_fall), .dq_oe_n(dq_oe_n));

/* dv/crdo_ctl_model.sv */
// ---------------------------------------------------------------
// Memory controller model driving commands on the link clock
// ---------------------------------------------------------------
module crdo_ctl_model (
  input  wire logic              dram_ck,
  output crdo_pkg::crdo_cmd_type cmd,
  output logic [2:0]             ba,
  output logic [15:0]            addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd  = 4'h8;
    ba   = 3'h0;
    addr = 16'h0000;
  end

  // One command, one no-operation, then deselect with stray lines.
  task automatic issue(input logic [3:0] c, input logic [2:0] b,
                       input logic [15:0] a, input int gap);
    @(posedge dram_ck);
    cmd  <= c;
    ba   <= b;
    addr <= a;
    @(posedge dram_ck);
    cmd  <= 4'h7;
    addr <= ~a;
    repeat (gap) begin
      @(posedge dram_ck);
      cmd  <= {1'b1, ~cmd.ras_n, ~cmd.cas_n, ~cmd.we_n};
      addr <= ~addr;
    end
  endtask : issue
endmodule : crdo_ctl_model

/* dv/crdo_top_bench.sv */
// ---------------------------------------------------------------
// Self-checking bench for the command side
// ---------------------------------------------------------------
module crdo_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] ARR = 128'hF00F_E11E_D22D_C33C_B44B_A55A_9669_8778;
  logic                   sys_clk   = 1'b0;
  logic                   dram_ck   = 1'b0;
  logic                   reset_n   = 1'b0;
  logic                   fill_zero = 1'b0;
  logic [127:0]           arr_rdata = ARR;
  logic                   mpr_active;
  logic                   dll_off;
  logic [15:0]            mpr_read_count;
  crdo_pkg::crdo_cmd_type cmd;
  logic [2:0]             ba;
  logic [15:0]            addr;
  crdo_pkg::crdo_arr_type arr_req;
  logic [15:0]            dq_rise;
  logic [15:0]            dq_fall;
  logic                   dq_oe_n;
  int                     fails     = 0;
  int                     tests_run = 0;
  logic [31:0]            cap_q[$];

  always #25 sys_clk = ~sys_clk;
  always #80 dram_ck = ~dram_ck;

  crdo_top #(.MAX_RL(24)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .fill_zero(fill_zero),
    .mpr_active(mpr_active), .dll_off(dll_off),
    .mpr_read_count(mpr_read_count), .dram_ck(dram_ck), .cmd(cmd),
    .ba(ba), .addr(addr), .arr_rdata(arr_rdata), .arr_req(arr_req),
    .dq_rise(dq_rise), .dq_fall(dq_fall), .dq_oe_n(dq_oe_n));

  crdo_ctl_model ctl (.dram_ck(dram_ck), .cmd(cmd), .ba(ba), .addr(addr));

  // Collect driven beat pairs on the falling edge, once they are settled.
  always @(negedge dram_ck) begin
    if (dq_oe_n === 1'b0) cap_q.push_back({dq_rise, dq_fall});
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic mrs(input logic [2:0] b, input logic [15:0] a);
    ctl.issue(4'h0, b, a, 6);
  endtask : mrs

  // Read with junk bank bits, then compare count and every beat pair.
  task automatic rd(input logic [15:0] a, input int n,
                    input logic [127:0] exp);
    cap_q.delete();
    ctl.issue(4'h5, 3'h7, a, 20);
    check(32'(cap_q.size()), 32'(n));
    for (int k = 0; k < n; k++) check(cap_q[k], exp[32*k +: 32]);
  endtask : rd

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // Cut a hang short well after the expected run length.
  initial begin
    #1000000;
    fails++;
    summarize();
  end

  // Main sequence of tests.
  initial begin
    logic [127:0] exp_a;
    for (int k = 0; k < 4; k++) begin
      exp_a[32*k +: 32] = {ARR[32*k +: 16], ARR[32*k+16 +: 16]};
    end
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge dram_ck);
    check({29'h0, mpr_active, dll_off, dq_oe_n}, 32'h1);
    check({16'h0, mpr_read_count}, 32'h0);
    $display("test reset done");
    mrs(3'h0, 16'h0020);
    mrs(3'h3, 16'h0004);
    check({31'h0, mpr_active}, 32'h1);
    rd(16'h07F8, 4, {4{32'h0000FFFF}});
    @(posedge sys_clk);
    fill_zero <= 1'b1;
    repeat (4) @(posedge dram_ck);
    rd(16'h0000, 4, {4{32'h00000101}});
    $display("test pattern done");
    mrs(3'h3, 16'h0000);
    mrs(3'h0, 16'h0021);
    mrs(3'h3, 16'h0004);
    rd(16'h0004, 2, {2{32'h00000101}});
    rd(16'h1000, 4, {4{32'h00000101}});
    mrs(3'h3, 16'h0000);
    mrs(3'h0, 16'h0022);
    mrs(3'h3, 16'h0004);
    rd(16'h0000, 2, {2{32'h00000101}});
    check({16'h0, mpr_read_count}, 32'h5);
    $display("test chop done");
    mrs(3'h3, 16'h0003);
    check({31'h0, mpr_active}, 32'h0);
    mrs(3'h0, 16'h0020);
    rd(16'h0408, 4, exp_a);
    ctl.issue(4'h4, 3'h2, 16'h0010, 14);
    check({16'h0, mpr_read_count}, 32'h5);
    mrs(3'h1, 16'h0008);
    rd(16'h0408, 4, exp_a);
    $display("test array done");
    mrs(3'h1, 16'h0001);
    check({31'h0, dll_off}, 32'h1);
    rd(16'h0000, 4, exp_a);
    mrs(3'h1, 16'h0000);
    check({31'h0, dll_off}, 32'h0);
    $display("test dll done");
    summarize();
  end
endmodule : crdo_top_bench

/* pkg/crdo_pkg.sv */
// What this block does
// - Readout mode turns on by mode register three write with A2=1, off with A2=0.
// - In readout mode every read returns pattern data, chosen by location bits A[1:0].
// - In readout mode a read with auto-precharge acts as a plain read.
// - With A2=0 reads and writes go to the array whatever A[1:0] hold.
// - Bit zero of both bytes carries the pattern; other bits repeat it or drive zero.
// - Readout reads use column A[1:0]=00; bank and column bits other than A2 for a chopped half are ignored.
// - Eight-beat order is 0..7; chopped half selected by A2 gives 0..3 or 4..7.
// - A12 selects chop on the fly when enabled; fixed chop is also honoured.
// - Beat zero carries the least significant pattern bit, beat seven the most.
// - Location 00 returns 0,1,0,1,0,1,0,1, or 0,1,0,1 for either chopped half.
// - Readout reads use the same read latency as ordinary array reads.
// - A no-operation command starts nothing and leaves running operations alone.
// - With chip select high the command inputs are ignored; running work continues.
// - Mode register one A0=1 disables the DLL until written back to 0.
// - In DLL-off mode CAS latency 6 and CAS write latency 6 are supported.
// - In DLL-off mode read data starts at AL+CL-1 cycles after the read.
package crdo_pkg;

  // ---------------------------------------------------------------
  // Mode register fields
  // ---------------------------------------------------------------
  localparam int          MR3_MPR_EN_BIT = 2;
  localparam int          MR3_LOC_LSB    = 0;
  localparam int          MR1_DLL_OFF    = 0;
  localparam int          MR1_AL_LSB     = 3;
  localparam int          MR0_BL_LSB     = 0;
  localparam int          MR0_CL_LSB     = 4;
  localparam int          ADDR_NIB_BIT   = 2;
  localparam int          ADDR_AP_BIT    = 10;
  localparam int          ADDR_BC_BIT    = 12;
  localparam logic [15:0] MR_RESET       = 16'h0000;

  // ---------------------------------------------------------------
  // Field codes and latency figures
  // ---------------------------------------------------------------
  localparam logic [1:0] AL_CL1    = 2'h1;
  localparam logic [1:0] AL_CL2    = 2'h2;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [4:0] CL_BASE   = 5'h04;
  localparam logic [4:0] DLL_OFF_CL = 5'h06;
  localparam int         RL_MAX_DEFAULT = 24;
  localparam int         RL_WORST  = 21;

  // ---------------------------------------------------------------
  // Pattern store and data layout
  // ---------------------------------------------------------------
  localparam logic [1:0] LOC_CAL     = 2'h0;
  localparam logic [7:0] CAL_PATTERN = 8'hAA;
  localparam int         BEAT_W      = 16;
  localparam int         BURST_BEATS = 8;
  localparam int         COL_W       = 10;
  localparam logic [1:0] PAIRS_BL8   = 2'h3;
  localparam logic [1:0] PAIRS_BC4   = 2'h1;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } crdo_cmd_type;

  typedef struct packed {
    logic             valid;
    logic             write;
    logic             auto_pre;
    logic [2:0]       bank;
    logic [COL_W-1:0] col;
  } crdo_arr_type;

  typedef struct packed {
    logic       valid;
    logic       calibration_pattern_register;
    logic       chop;
    logic       upper;
    logic [1:0] loc;
  } crdo_slot_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_BURST = 2'b10
  } crdo_state_type;

endpackage : crdo_pkg

/* verilog/crdo_sync.sv */
// ---------------------------------------------------------------
// Two-stage synchroniser
// ---------------------------------------------------------------
module crdo_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_chk
    $error("crdo_sync needs WIDTH of at least one.");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : crdo_sync

/* verilog/crdo_top.sv */
// ---------------------------------------------------------------
// Command side of the memory device: mode registers, calibration
// pattern readout, read latency and DLL-off timing.
// ---------------------------------------------------------------
module crdo_top #(
  parameter int MAX_RL = crdo_pkg::RL_MAX_DEFAULT
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic                   fill_zero,
  output logic                        mpr_active,
  output logic                        dll_off,
  output logic [15:0]                 mpr_read_count,
  input  wire logic                   dram_ck,
  input  wire crdo_pkg::crdo_cmd_type cmd,
  input  wire logic [2:0]             ba,
  input  wire logic [15:0]            addr,
  input  wire logic [127:0]           arr_rdata,
  output crdo_pkg::crdo_arr_type      arr_req,
  output logic [15:0]                 dq_rise,
  output logic [15:0]                 dq_fall,
  output logic                        dq_oe_n
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic                    link_rst_n;
  logic                    fill_zero_l;
  logic [15:0]             mr0_r;
  logic [15:0]             mr1_r;
  logic [15:0]             mr2_r;
  logic [15:0]             mr3_r;
  logic                    selected;
  logic                    is_mrs;
  logic                    is_rd;
  logic                    is_wr;
  logic                    mpr_en;
  logic                    dll_off_l;
  logic [1:0]              mpr_loc;
  logic [4:0]              cl;
  logic [4:0]              al;
  logic [5:0]              rl;
  logic [5:0]              rl_m1;
  logic                    chop;
  crdo_pkg::crdo_slot_type new_slot;
  crdo_pkg::crdo_slot_type pipe_r [MAX_RL];
  crdo_pkg::crdo_arr_type  arr_req_r;
  crdo_pkg::crdo_state_type state_r;
  logic [1:0]              left_r;
  logic [95:0]             burst_r;
  logic [31:0]             dq_r;
  logic                    oe_n_r;
  logic                    load;
  logic [127:0]            word;
  logic [127:0]            base;
  logic                    mpr_tog_r;
  logic [1:0]              stat_s;
  logic                    tog_s;
  logic                    tog_d_r;
  logic [15:0]             count_r;

  if (MAX_RL < crdo_pkg::RL_WORST || MAX_RL > 63) begin : g_chk
    $error("crdo_top MAX_RL must lie between 21 and 63.");
  end

  // ---------------------------------------------------------------
  // Reset and configuration into the link clock
  // ---------------------------------------------------------------

  // Reset release is retimed so link flops leave reset together.
  crdo_sync #(
    .WIDTH (1)
  ) u_link_rst (
    .clk   (dram_ck),
    .rst_n (reset_n),
    .d     (1'b1),
    .q     (link_rst_n)
  );

  // The lane fill choice comes from the system clock side.
  crdo_sync #(
    .WIDTH (1)
  ) u_fill (
    .clk   (dram_ck),
    .rst_n (link_rst_n),
    .d     (fill_zero),
    .q     (fill_zero_l)
  );

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------

  // Deselect and no-operation match no command and start nothing.
  assign selected = !cmd.cs_n;
  assign is_mrs = selected && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
  assign is_rd  = selected && cmd.ras_n && !cmd.cas_n && cmd.we_n;
  assign is_wr  = selected && cmd.ras_n && !cmd.cas_n && !cmd.we_n;

  // ---------------------------------------------------------------
  // Mode registers
  // ---------------------------------------------------------------

  // A mode register set loads the register named by the bank bits.
  always_ff @(posedge dram_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      mr0_r <= crdo_pkg::MR_RESET;
      mr1_r <= crdo_pkg::MR_RESET;
      mr2_r <= crdo_pkg::MR_RESET;
      mr3_r <= crdo_pkg::MR_RESET;
    end else if (is_mrs && !ba[2]) begin
      unique case (ba[1:0])
        2'h0: mr0_r <= addr;
        2'h1: mr1_r <= addr;
        2'h2: mr2_r <= addr;
        2'h3: mr3_r <= addr;
      endcase
    end
  end

  // Readout state and DLL state follow their mode register bits.
  assign mpr_en    = mr3_r[crdo_pkg::MR3_MPR_EN_BIT];
  assign mpr_loc   = mr3_r[crdo_pkg::MR3_LOC_LSB +: 2];
  assign dll_off_l = mr1_r[crdo_pkg::MR1_DLL_OFF];

  // ---------------------------------------------------------------
  // Latency and burst length
  // ---------------------------------------------------------------

  // CAS latency from its field; additive latency from mode one.
  always_comb begin
    cl = crdo_pkg::CL_BASE + 5'(mr0_r[crdo_pkg::MR0_CL_LSB +: 3]);
    unique case (mr1_r[crdo_pkg::MR1_AL_LSB +: 2])
      crdo_pkg::AL_CL1: al = cl - 5'h01;
      crdo_pkg::AL_CL2: al = cl - 5'h02;
      default:          al = 5'h00;
    endcase
  end

  // DLL-off reads launch one cycle earlier than DLL-on reads.
  assign rl = 6'(al) + 6'(cl) - (dll_off_l ? 6'h01 : 6'h00);
  assign rl_m1 = rl - 6'h01;

  // Chop is fixed by mode zero or taken from A12 on the fly.
  always_comb begin
    unique case (mr0_r[crdo_pkg::MR0_BL_LSB +: 2])
      crdo_pkg::BL_OTF:    chop = !addr[crdo_pkg::ADDR_BC_BIT];
      crdo_pkg::BL_FIXED4: chop = 1'b1;
      default:             chop = 1'b0;
    endcase
  end

  // A read slot: bank bits, A10 and high column bits are not used.
  always_comb begin
    new_slot       = '0;
    new_slot.valid = is_rd;
    new_slot.calibration_pattern_register   = mpr_en;
    new_slot.chop  = chop;
    new_slot.upper = chop && addr[crdo_pkg::ADDR_NIB_BIT];
    new_slot.loc   = mpr_loc;
  end

  // ---------------------------------------------------------------
  // Array requests
  // ---------------------------------------------------------------

  // Only normal mode reaches the array; readout reads do not, and
  // their auto-precharge flag is dropped along with the request.
  always_ff @(posedge dram_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      arr_req_r <= '0;
    end else begin
      arr_req_r          <= '0;
      arr_req_r.valid    <= (is_rd || is_wr) && !mpr_en;
      arr_req_r.write    <= is_wr;
      arr_req_r.auto_pre <= addr[crdo_pkg::ADDR_AP_BIT];
      arr_req_r.bank     <= ba;
      arr_req_r.col      <= addr[crdo_pkg::COL_W-1:0];
    end
  end

  assign arr_req = arr_req_r;

  // ---------------------------------------------------------------
  // Read latency line
  // ---------------------------------------------------------------

  // Each read enters at its latency less one and walks to slot 0;
  // pattern reads use the same line as array reads.
  always_ff @(posedge dram_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      for (int i = 0; i < MAX_RL; i++) begin
        pipe_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < MAX_RL; i++) begin
        if (is_rd && i == int'(rl_m1)) begin
          pipe_r[i] <= new_slot;
        end else if (i == MAX_RL - 1) begin
          pipe_r[i] <= '0;
        end else begin
          pipe_r[i] <= pipe_r[(i + 1) % MAX_RL];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Burst data
  // ---------------------------------------------------------------

  // Pattern word: beat b takes pattern bit b; bit 0 of each byte
  // carries it and the other bits copy it or stay low.
  function automatic logic [127:0] mpr_word(
    input logic [1:0] loc,
    input logic       zero
  );
    logic [127:0] w;
    logic         bitv;
    logic [7:0]   lane;
    w = '0;
    for (int b = 0; b < crdo_pkg::BURST_BEATS; b++) begin
      bitv = (loc == crdo_pkg::LOC_CAL) ?
             crdo_pkg::CAL_PATTERN[b] : 1'b0;
      lane = zero ? {7'h00, bitv} : {8{bitv}};
      w[b*crdo_pkg::BEAT_W +: crdo_pkg::BEAT_W] = {lane, lane};
    end
    return w;
  endfunction : mpr_word

  // Select the source and skip to beat 4 for an upper chopped half.
  always_comb begin
    base = pipe_r[0].calibration_pattern_register ? mpr_word(pipe_r[0].loc, fill_zero_l)
                         : arr_rdata;
    word = pipe_r[0].upper ? (base >> 64) : base;
  end

  assign load = pipe_r[0].valid &&
                (state_r == crdo_pkg::ST_IDLE || left_r == 2'h0);

  // Two beats per clock: rising beat low half, falling beat high.
  always_ff @(posedge dram_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_r <= crdo_pkg::ST_IDLE;
      left_r  <= 2'h0;
      burst_r <= '0;
      dq_r    <= '0;
      oe_n_r  <= 1'b1;
    end else if (load) begin
      state_r <= crdo_pkg::ST_BURST;
      left_r  <= pipe_r[0].chop ? crdo_pkg::PAIRS_BC4
                                : crdo_pkg::PAIRS_BL8;
      dq_r    <= word[31:0];
      burst_r <= word[127:32];
      oe_n_r  <= 1'b0;
    end else begin
      unique case (state_r)
        crdo_pkg::ST_IDLE: begin
          dq_r   <= '0;
          oe_n_r <= 1'b1;
        end
        crdo_pkg::ST_BURST: begin
          if (left_r != 2'h0) begin
            left_r  <= left_r - 2'h1;
            dq_r    <= burst_r[31:0];
            burst_r <= {32'h0000_0000, burst_r[95:32]};
          end else begin
            state_r <= crdo_pkg::ST_IDLE;
            dq_r    <= '0;
            oe_n_r  <= 1'b1;
          end
        end
        default: begin
          state_r <= crdo_pkg::ST_IDLE;
          oe_n_r  <= 1'b1;
        end
      endcase
    end
  end

  assign dq_rise = dq_r[15:0];
  assign dq_fall = dq_r[31:16];
  assign dq_oe_n = oe_n_r;

  // ---------------------------------------------------------------
  // Status toward the system clock
  // ---------------------------------------------------------------

  // Each pattern burst start flips a toggle for the other domain.
  always_ff @(posedge dram_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      mpr_tog_r <= 1'b0;
    end else if (load && pipe_r[0].calibration_pattern_register) begin
      mpr_tog_r <= !mpr_tog_r;
    end
  end

  // Mode levels cross by two flops each.
  crdo_sync #(
    .WIDTH (2)
  ) u_stat (
    .clk   (sys_clk),
    .rst_n (reset_n),
    .d     ({dll_off_l, mpr_en}),
    .q     (stat_s)
  );

  // The toggle crosses the same way; edges are found after it.
  crdo_sync #(
    .WIDTH (1)
  ) u_tog (
    .clk   (sys_clk),
    .rst_n (reset_n),
    .d     (mpr_tog_r),
    .q     (tog_s)
  );

  // Count pattern bursts; the counter wraps at its width.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tog_d_r <= 1'b0;
      count_r <= 16'h0000;
    end else begin
      tog_d_r <= tog_s;
      if (tog_s != tog_d_r) begin
        count_r <= count_r + 16'h0001;
      end
    end
  end

  assign mpr_active     = stat_s[0];
  assign dll_off        = stat_s[1];
  assign mpr_read_count = count_r;

endmodule : crdo_top
